// ---- design/ctr_regs.sv ----
// transceiver control and status register bank
// assumes a serial-interface front end that presents decoded byte accesses on clock
// and on-chip event inputs already synchronous to clock
//
// Behaviour
// - control bit 6 enables tolerance of flexible-data-rate frames
// - control bit 5 confirms filter setup; zero means standard wake pattern only
// - control bit 4 enables frame-based selective wake-up
// - shutdown field 00 keeps transceiver running on battery interrupts
// - field 01 in Normal mode shuts down on battery undervoltage
// - field 10 in Normal mode shuts down on battery overvoltage
// - field 11 in Normal mode shuts down on either battery interrupt
// - mode 00 selects offline, mode 11 selects listen-only
// - mode 01 selects active in Normal mode with supply undervoltage detection
// - mode 10 selects active in Normal mode without supply undervoltage detection
// - status bit 7 reads one when transmitter ready, zero when disabled
// - bits 6:4 exist only on partial-networking variants, else reserved
// - confirmation bit clears after any write to a filter configuration register
// - with tolerance on, error counter decrements on each FD control field
//
// notes for the next engineer
// - the shutdown latch is this block's own choice: once tripped it keeps the
//   transmitter off until software rewrites the control register or the chip
//   leaves Normal mode, so a short battery interrupt is not lost
// - a latched shutdown only counts while the shutdown field still asks for it,
//   so rewriting the field to 00 lets the transmitter run again at once
// - tx_ready is registered and trails tx_active by one clock, except on a battery trip, which drops both on the same edge
// - the error counter stops at zero; an increment at the top value sets the
//   sticky frame detect error, which only bias_off or reset clears
// - bias_off wins over every frame event; an FD control field wins over the
//   frame error and frame ok strobes of the same cycle
// - on a variant without partial networking bits 6:4 store and read zero
// - reads of unmapped addresses return zero; writes to them are dropped
// - control writes land on the rising edge that samples reg_wr; the new
//   settings drive the outputs from the following cycle
// - the battery interrupt inputs may be levels or pulses; a level keeps
//   tripping the latch for as long as it stays high in Normal mode
// - dominant_timeout only gates readiness; its own status bit lives elsewhere
// - all inputs are expected synchronous to clock
// - mode 11 leaves the transmitter off but keeps supply detection running in Normal mode
// - mode 00 turns every transmit path off regardless of the chip state
`default_nettype none
module ctr_regs #(
  parameter bit PN_VARIANT = 1'b1
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [6:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // chip state and events
  input  wire logic        normal_mode,
  input  wire logic        battery_undervoltage_irq,
  input  wire logic        battery_overvoltage_irq,
  input  wire logic        pn_cfg_write,
  input  wire logic        fd_control_field,
  input  wire logic        frame_error,
  input  wire logic        frame_ok,
  input  wire logic        dominant_timeout,
  input  wire logic        bias_off,
  // transceiver controls
  output logic             fd_tolerance_enable,
  output logic             pn_config_confirmed,
  output logic             selective_wake_enable,
  output logic      [1:0]  shutdown_control,
  output ctr_pkg::ctr_mode_type transceiver_mode_select,
  output logic             tx_active,
  output logic             supply_uv_detect_en,
  output logic             listen_only,
  output logic             tx_ready,
  output logic             frame_detect_error,
  output logic      [5:0]  pn_error_count
);
  import ctr_pkg::*;

  // true for the two mode codes that put the transmitter in active mode
  function automatic logic mode_is_active(input logic [1:0] code);
    return (code == CTR_MODE_ACT_UV) || (code == CTR_MODE_ACT_NUV);
  endfunction

  // true for the two mode codes that watch the transceiver supply
  function automatic logic mode_watches_supply(input logic [1:0] code);
    return (code == CTR_MODE_ACT_UV) || (code == CTR_MODE_LISTEN);
  endfunction

  logic [7:0] ctrl_r;
  logic       shut_r;
  logic       shut_eff;
  logic       ctrl_wr;
  logic [1:0] mode_bits;
  logic       batt_trip;
  logic       txrdy_r;
  logic [5:0] errcnt_r;
  logic       fderr_r;

  assign ctrl_wr   = reg_wr && (reg_addr == CTR_ADDR_CTRL);
  assign mode_bits = ctrl_r[CTR_MODE_LSB +: 2];

  // a latched shutdown applies only while the field still selects a trip source
  assign shut_eff  = shut_r && (ctrl_r[CTR_SHUT_LSB +: 2] != CTR_SHUT_NONE);

  // control register; bit 7 stored as zero whatever is written
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTR_CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_r[CTR_RSVD_BIT]       <= 1'b0;
        ctrl_r[CTR_FDT_BIT]        <= PN_VARIANT & reg_wdata[CTR_FDT_BIT];
        ctrl_r[CTR_SWK_BIT]        <= PN_VARIANT & reg_wdata[CTR_SWK_BIT];
        ctrl_r[CTR_SHUT_LSB +: 2]  <= reg_wdata[CTR_SHUT_LSB +: 2];
        ctrl_r[CTR_MODE_LSB +: 2]  <= reg_wdata[CTR_MODE_LSB +: 2];
      end
      // a filter write clears the confirmation, and wins over a same-cycle set
      if (pn_cfg_write) begin
        ctrl_r[CTR_PNOK_BIT] <= 1'b0;
      end else if (ctrl_wr) begin
        ctrl_r[CTR_PNOK_BIT] <= PN_VARIANT & reg_wdata[CTR_PNOK_BIT];
      end
    end
  end

  // battery interrupt selection per shutdown field
  always_comb begin
    unique case (ctrl_r[CTR_SHUT_LSB +: 2])
      CTR_SHUT_NONE: batt_trip = 1'b0;
      CTR_SHUT_UV:   batt_trip = battery_undervoltage_irq;
      CTR_SHUT_OV:   batt_trip = battery_overvoltage_irq;
      CTR_SHUT_BOTH: batt_trip = battery_undervoltage_irq
                                 | battery_overvoltage_irq;
    endcase
  end

  // shutdown latch; set in Normal mode, released by any control write or by leaving Normal mode
  // the set wins over a same-cycle control write so an interrupt arriving
  // together with a write is not dropped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shut_r <= 1'b0;
    end else if (normal_mode && batt_trip) begin
      shut_r <= 1'b1;
    end else if (ctrl_wr || !normal_mode) begin
      shut_r <= 1'b0;
    end
  end

  // transmitter readiness: active mode, not shut down, no dominant timeout
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txrdy_r <= 1'b0;
    end else begin
      txrdy_r <= tx_active && !shut_eff && !batt_trip && !dominant_timeout;
    end
  end

  // error counter policy:
  //   bias_off          -> counter and error flag cleared
  // fd field, tol on -> count down, stop at zero
  //   fd field, tol off -> counted as a bad frame
  //   frame_error       -> count up, overflow sets the flag
  //   frame_ok          -> count down, stop at zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      errcnt_r <= CTR_ERRCNT_RESET;
      fderr_r  <= 1'b0;
    end else if (bias_off) begin
      errcnt_r <= CTR_ERRCNT_RESET;
      fderr_r  <= 1'b0;
    end else if (fd_control_field) begin
      if (ctrl_r[CTR_FDT_BIT]) begin
        if (errcnt_r != CTR_ERRCNT_RESET) begin
          errcnt_r <= errcnt_r - 6'h01;
        end
      end else if (errcnt_r == CTR_ERRCNT_MAX) begin
        fderr_r <= 1'b1;
      end else begin
        errcnt_r <= errcnt_r + 6'h01;
      end
    end else if (frame_error) begin
      if (errcnt_r == CTR_ERRCNT_MAX) begin
        fderr_r <= 1'b1;
      end else begin
        errcnt_r <= errcnt_r + 6'h01;
      end
    end else if (frame_ok && errcnt_r != CTR_ERRCNT_RESET) begin
      errcnt_r <= errcnt_r - 6'h01;
    end
  end

  // read data register; unmapped addresses read zero
  // status bits other than transmitter ready lie in other blocks and read zero here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == CTR_ADDR_CTRL) begin
        reg_rdata <= ctrl_r;
      end else if (reg_addr == CTR_ADDR_STATUS) begin
        reg_rdata <= {txrdy_r, 7'h00};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // decoded controls
  // the mode outputs follow the register, so a mode write reaches the transceiver
  // on the clock after the write strobe
  assign fd_tolerance_enable     = ctrl_r[CTR_FDT_BIT];
  assign pn_config_confirmed     = ctrl_r[CTR_PNOK_BIT];
  assign selective_wake_enable   = ctrl_r[CTR_SWK_BIT];
  assign shutdown_control        = ctrl_r[CTR_SHUT_LSB +: 2];
  assign transceiver_mode_select = ctr_mode_type'(mode_bits);
  assign tx_active   = normal_mode && !shut_eff && mode_is_active(mode_bits);
  assign supply_uv_detect_en = normal_mode && mode_watches_supply(mode_bits);
  assign listen_only = (mode_bits == CTR_MODE_LISTEN);
  assign tx_ready           = txrdy_r;
  assign frame_detect_error = fderr_r;
  assign pn_error_count     = errcnt_r;
endmodule
`default_nettype wire

// ---- include/ctr_pkg.sv ----
// package for the transceiver control and status register bank
// assumes a byte-wide register port with 7-bit addresses
`default_nettype none
package ctr_pkg;
  // register addresses
  localparam logic [6:0] CTR_ADDR_CTRL     = 7'h20;
  localparam logic [6:0] CTR_ADDR_STATUS   = 7'h22;
  // control register fields
  localparam int         CTR_RSVD_BIT      = 7;
  localparam int         CTR_FDT_BIT       = 6;
  localparam int         CTR_PNOK_BIT      = 5;
  localparam int         CTR_SWK_BIT       = 4;
  localparam int         CTR_SHUT_LSB      = 2;
  localparam int         CTR_MODE_LSB      = 0;
  // status register field
  localparam int         CTR_TXRDY_BIT     = 7;
  // reset values
  localparam logic [7:0] CTR_CTRL_RESET    = 8'h00;
  localparam logic [5:0] CTR_ERRCNT_RESET  = 6'h00;
  // error counter overflow limit
  localparam logic [5:0] CTR_ERRCNT_MAX    = 6'h1f;
  // shutdown control codes
  localparam logic [1:0] CTR_SHUT_NONE     = 2'h0;
  localparam logic [1:0] CTR_SHUT_UV       = 2'h1;
  localparam logic [1:0] CTR_SHUT_OV       = 2'h2;
  localparam logic [1:0] CTR_SHUT_BOTH     = 2'h3;
  // transceiver mode codes
  typedef enum logic [1:0] {
    CTR_MODE_OFFLINE = 2'h0,
    CTR_MODE_ACT_UV  = 2'h1,
    CTR_MODE_ACT_NUV = 2'h2,
    CTR_MODE_LISTEN  = 2'h3
  } ctr_mode_type;
endpackage
`default_nettype wire

// ---- tb/ctr_regs_monitor.sv ----
// assertion checker for the transceiver control and status register bank
// assumes it is bound onto ctr_regs and sees only that module's ports
`default_nettype none
module ctr_regs_monitor
  import ctr_pkg::*;
#(
  parameter bit PN_VARIANT = 1'b1
) (
  // clock, reset and register port
  input wire logic        clock, rst_n, reg_wr, reg_rd,
  input wire logic [6:0]  reg_addr,
  input wire logic [7:0]  reg_wdata, reg_rdata,
  // chip state and events
  input wire logic        normal_mode, pn_cfg_write,
  input wire logic        battery_undervoltage_irq, battery_overvoltage_irq,
  // transceiver controls
  input wire logic        fd_tolerance_enable, pn_config_confirmed, selective_wake_enable,
  input wire logic [1:0]  shutdown_control,
  input wire ctr_pkg::ctr_mode_type transceiver_mode_select,
  input wire logic        tx_active, supply_uv_detect_en, tx_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // control write decode and the two active codes
  wire logic ctl_wr = reg_wr && reg_addr == CTR_ADDR_CTRL;
  wire logic act = transceiver_mode_select inside {CTR_MODE_ACT_UV, CTR_MODE_ACT_NUV};
  // written fields appear on the control outputs
  a_ctrl_low_field: assert property (ctl_wr |=>
    {shutdown_control, transceiver_mode_select} == $past(reg_wdata[3:0])) else $error("low bits");
  a_pn_bits_write: assert property (ctl_wr && !pn_cfg_write |=>
    {fd_tolerance_enable, pn_config_confirmed, selective_wake_enable}
    == (PN_VARIANT ? $past(reg_wdata[6:4]) : 3'h0)) else $error("pn bits");
  a_pnok_auto_clear: assert property (pn_cfg_write |=> !pn_config_confirmed)
    else $error("confirm bit kept");
  a_status_ready_read: assert property (reg_rd && reg_addr == CTR_ADDR_STATUS |=>
    reg_rdata[CTR_TXRDY_BIT] == $past(tx_ready)) else $error("status bit 7");
  a_supply_uv_detect: assert property (supply_uv_detect_en ==
    (normal_mode && transceiver_mode_select[0])) else $error("uv detect");
  a_tx_mode_gate: assert property (!normal_mode || !act |-> !tx_active)
    else $error("tx on in wrong mode");
  a_no_shutdown: assert property (normal_mode && act && shutdown_control == CTR_SHUT_NONE
    |-> tx_active) else $error("tx off");
  a_uv_shutdown: assert property (normal_mode && shutdown_control[0]
    && battery_undervoltage_irq && !reg_wr |=> !tx_active ##1 !tx_ready) else $error("uv");
  a_ov_shutdown: assert property (normal_mode && shutdown_control[1]
    && battery_overvoltage_irq && !reg_wr |=> !tx_active ##1 !tx_ready) else $error("ov");
endmodule
`default_nettype wire

// ---- tb/test_ctr_regs.sv ----
// self-checking bench for the transceiver control and status register bank
// assumes ctr_pkg and ctr_regs compiled first; the checker is bound below
`default_nettype none
module test_ctr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import ctr_pkg::*;
  logic       clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, normal_mode = 1, rd_seen = 0;
  logic       pn_cfg_write = 0, battery_undervoltage_irq = 0, battery_overvoltage_irq = 0;
  logic [6:0] reg_addr = 0;
  logic       fd_control_field = 0, frame_error = 0, frame_ok = 0, listen_only;
  logic [5:0] pn_error_count;
  logic [7:0] reg_wdata = 0, reg_rdata, d, eq[$], mq[$];
  int         err_total = 0, comparisons = 0;
  // 250 MHz clock
  always #2 clock = ~clock;
  ctr_regs uut (.clock, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .normal_mode, .battery_undervoltage_irq, .battery_overvoltage_irq, .pn_cfg_write,
    .fd_control_field, .frame_error, .frame_ok, .dominant_timeout(1'h0),
    .bias_off(1'h0), .fd_tolerance_enable(), .pn_config_confirmed(),
    .selective_wake_enable(), .shutdown_control(), .transceiver_mode_select(),
    .tx_active(), .supply_uv_detect_en(), .listen_only, .tx_ready(),
    .frame_detect_error(), .pn_error_count);
  // one byte write, strobe held for one edge
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge clock);
    {reg_wr, reg_addr, reg_wdata} = {1'h1, a, v};
    @(negedge clock);
    reg_wr = 0;
  endtask
  // one byte read; the expectation and its mask go on the queues
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m);
    @(negedge clock);
    {reg_rd, reg_addr} = {1'h1, a};
    eq.push_back(e);
    mq.push_back(m);
    @(negedge clock);
    reg_rd = 0;
  endtask
  // one-cycle event pulse: 0 undervoltage, 1 overvoltage, 2 filter write,
  // 3 fd control field, 4 frame error, 5 frame ok
  task automatic pulse(input int k);
    @(negedge clock);
    {frame_ok, frame_error, fd_control_field, pn_cfg_write, battery_overvoltage_irq,
     battery_undervoltage_irq} = 6'h01 << k;
    @(negedge clock);
    {frame_ok, frame_error, fd_control_field, pn_cfg_write, battery_overvoltage_irq,
     battery_undervoltage_irq} = 6'h00;
  endtask
  // direct compare of a settled output
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] m);
    comparisons++;
    if ((reg_rdata & m) !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, reg_rdata & m);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // read data lands one edge after the strobe; compare against the oldest note
  always @(posedge clock) rd_seen <= reg_rd;
  always @(negedge clock) if (rd_seen) cmp("reg_rdata", eq.pop_front(), mq.pop_front());
  // watchdog
  initial begin
    #40000;
    err_total++;
    final_report;
  end
  initial begin
    void'($urandom(54230));
    repeat (5) @(negedge clock);
    rst_n = 1;
    rd(CTR_ADDR_CTRL, CTR_CTRL_RESET, 8'hff);
    rd(CTR_ADDR_STATUS, 8'h00, 8'h80);
    $display("reset values done");
    // every mode and shutdown code, random upper bits and chip state
    for (int i = 0; i < 24; i++) begin
      d = $urandom;
      d[7] = 1'h0;
      if (i < 16) d[3:0] = i[3:0];
      normal_mode = $urandom;
      wr(CTR_ADDR_CTRL, d);
      chk("listen_only", {7'h0, d[1:0] == 2'h3}, {7'h0, listen_only});
      rd(CTR_ADDR_CTRL, d, 8'hff);
      rd(CTR_ADDR_STATUS, {normal_mode & (d[1] ^ d[0]), 7'h0}, 8'h80);
    end
    $display("control fields done");
    normal_mode = 1;
    for (int s = 0; s < 8; s++) begin
      wr(CTR_ADDR_CTRL, {4'h0, s[1:0], 2'h1});
      pulse(s[2]);
      rd(CTR_ADDR_STATUS, {!(s[2] ? s[1] : s[0]), 7'h0}, 8'h80);
    end
    $display("shutdown codes done");
    wr(CTR_ADDR_CTRL, 8'h20);
    pulse(2);
    rd(CTR_ADDR_CTRL, 8'h00, 8'hff);
    wr(CTR_ADDR_STATUS, 8'hff);
    wr(7'h21, 8'h7f);
    rd(CTR_ADDR_CTRL, 8'h00, 8'hff);
    rd(7'h21, 8'h00, 8'hff);
    $display("clear and ignored writes done");
    // error counter: three bad frames, then FD fields with and without tolerance
    wr(CTR_ADDR_CTRL, 8'h40);
    repeat (3) pulse(4);
    chk("pn_error_count", 8'h03, {2'h0, pn_error_count});
    pulse(3);
    chk("pn_error_count", 8'h02, {2'h0, pn_error_count});
    wr(CTR_ADDR_CTRL, 8'h00);
    pulse(3);
    chk("pn_error_count", 8'h03, {2'h0, pn_error_count});
    pulse(5);
    chk("pn_error_count", 8'h02, {2'h0, pn_error_count});
    $display("error counter done");
    repeat (2) @(negedge clock);
    final_report;
  end
endmodule
bind ctr_regs ctr_regs_monitor #(.PN_VARIANT(PN_VARIANT)) mon (.clock, .rst_n, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .normal_mode, .pn_cfg_write,
  .battery_undervoltage_irq, .battery_overvoltage_irq, .fd_tolerance_enable,
  .pn_config_confirmed, .selective_wake_enable, .shutdown_control,
  .transceiver_mode_select, .tx_active, .supply_uv_detect_en, .tx_ready);
`default_nettype wire
